// file: cpwm_pkg.sv
package cpwm_pkg;

  // ---------------------------------------------------------------
  // Register map, byte addresses of aligned words.
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_START = 8'h04;
  localparam logic [7:0] ADDR_WAVE = 8'h08;
  localparam logic [7:0] ADDR_OUTEN = 8'h0C;
  localparam logic [7:0] ADDR_IOCTL = 8'h10;
  localparam logic [7:0] ADDR_DEAD = 8'h14;
  localparam logic [7:0] ADDR_CYCBUF = 8'h18;
  localparam logic [7:0] ADDR_UPBUF = 8'h1C;
  localparam logic [7:0] ADDR_CYCLE = 8'h20;
  localparam logic [7:0] ADDR_UPPER = 8'h24;
  localparam logic [7:0] ADDR_CNT3 = 8'h28;
  localparam logic [7:0] ADDR_CNT4 = 8'h2C;
  localparam int ADDR_W = 8;

  // ---------------------------------------------------------------
  // Field positions and reset values.
  // ---------------------------------------------------------------
  localparam int WAVE_CCE_BIT = 7;
  localparam int WAVE_WRE_BIT = 0;
  localparam int NPIN = 6;
  localparam int NPH = 3;
  localparam logic [15:0] TIMER_RST = 16'hFFFF;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [5:0] PIN_RST = 6'h00;
  localparam logic [2:0] PH_ALL = 3'h7;

  // ---------------------------------------------------------------
  // Mode codes held in the transfer timing bits.
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PWM1 = 4'h2;
  localparam logic [3:0] MODE_CMP_CREST = 4'hD;
  localparam logic [3:0] MODE_CMP_TROUGH = 4'hE;
  localparam logic [3:0] MODE_CMP_BOTH = 4'hF;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic rd;
  } cpwm_aphase_t;

  typedef struct packed {
    logic [NPIN-1:0] level;
    logic [NPIN-1:0] oe;
  } cpwm_pins_t;

endpackage

// file: cpwm_cycle_ctrl.sv
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cpwm_cycle_ctrl
  import cpwm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Standby request from the power controller.
  input wire logic standby,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Gate drive pins, positive phases in bits 2 to 0.
  output logic [cpwm_pkg::NPIN-1:0] gate_out,
  output logic [cpwm_pkg::NPIN-1:0] gate_oe
);
  import cpwm_pkg::*;

  // ---------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------
  cpwm_aphase_t aph_q;
  logic [3:0] timer_mode_reg_q;
  logic count_start_q;
  logic counter_clear_on_match_enable_q;
  logic trough_write_enable_q;
  logic cce_read_zero_q;
  logic [NPIN-1:0] output_master_enable_q;
  logic [NPIN-1:0] io_control_q;
  logic [15:0] dead_time_data_q;
  logic [15:0] cycle_buffer_q;
  logic [15:0] ch3_upper_limit_buffer_q;
  logic [15:0] cycle_data_q;
  logic [15:0] ch3_upper_limit_q;
  logic [15:0] ch3_counter_q;
  logic [15:0] ch4_counter_q;
  logic count_up_q;
  cpwm_pins_t pins_q;
  logic [31:0] hrdata_q;
  logic [NPIN-1:0] level_d;

  // ---------------------------------------------------------------
  // Bus decode.
  // ---------------------------------------------------------------
  wire logic take = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire logic [ADDR_W-1:0] a_now = haddr[ADDR_W-1:0];
  wire logic wr = aph_q.wr;
  wire logic [ADDR_W-1:0] wa = aph_q.addr;
  wire logic wr_mode = wr && (wa == ADDR_MODE);
  wire logic wr_start = wr && (wa == ADDR_START);
  wire logic wr_wave = wr && (wa == ADDR_WAVE);
  wire logic wr_outen = wr && (wa == ADDR_OUTEN);
  wire logic wr_ioctl = wr && (wa == ADDR_IOCTL);
  wire logic wr_dead = wr && (wa == ADDR_DEAD);
  wire logic wr_cycbuf = wr && (wa == ADDR_CYCBUF);
  wire logic wr_upbuf = wr && (wa == ADDR_UPBUF);
  wire logic rd_wave_now = take && !hwrite && (a_now == ADDR_WAVE);

  // ---------------------------------------------------------------
  // Mode decode and counting events.
  // ---------------------------------------------------------------
  function automatic logic is_cmp(input logic [3:0] m);
    is_cmp = (m == MODE_CMP_CREST) || (m == MODE_CMP_TROUGH) || (m == MODE_CMP_BOTH);
  endfunction

  wire logic cmp_mode = is_cmp(timer_mode_reg_q);
  wire logic running = count_start_q;
  // The ch3 upper limit bounds counter 3 and the cycle data bounds counter 4.
  wire logic crest = running && cmp_mode && count_up_q && (ch3_counter_q == ch3_upper_limit_q);
  wire logic trough = running && cmp_mode && !count_up_q && (ch4_counter_q == CNT_RST);
  wire logic match_clear = crest && counter_clear_on_match_enable_q;
  wire logic xfer_crest = crest && ((timer_mode_reg_q == MODE_CMP_CREST) || (timer_mode_reg_q == MODE_CMP_BOTH));
  wire logic xfer_trough = trough && ((timer_mode_reg_q == MODE_CMP_TROUGH) || (timer_mode_reg_q == MODE_CMP_BOTH));
  wire logic xfer = xfer_crest || xfer_trough;
  wire logic cce_set = wr_wave && hwdata[WAVE_CCE_BIT] && cce_read_zero_q;

  // ---------------------------------------------------------------
  // Read data mux.
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (a_now)
      ADDR_MODE: rd_mux[3:0] = timer_mode_reg_q;
      ADDR_START: rd_mux[0] = count_start_q;
      ADDR_WAVE:
      begin
        // Bits 6 to 1 stay zero whatever was written.
        rd_mux[WAVE_CCE_BIT] = counter_clear_on_match_enable_q;
        rd_mux[WAVE_WRE_BIT] = trough_write_enable_q;
      end
      ADDR_OUTEN: rd_mux[NPIN-1:0] = output_master_enable_q;
      ADDR_IOCTL: rd_mux[NPIN-1:0] = io_control_q;
      ADDR_DEAD: rd_mux[15:0] = dead_time_data_q;
      ADDR_CYCBUF: rd_mux[15:0] = cycle_buffer_q;
      ADDR_UPBUF: rd_mux[15:0] = ch3_upper_limit_buffer_q;
      ADDR_CYCLE: rd_mux[15:0] = cycle_data_q;
      ADDR_UPPER: rd_mux[15:0] = ch3_upper_limit_q;
      ADDR_CNT3: rd_mux[15:0] = ch3_counter_q;
      ADDR_CNT4: rd_mux[15:0] = ch4_counter_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Pin levels.
  // ---------------------------------------------------------------
  always_comb
  begin
    level_d = pins_q.level;
    if (wr_mode && (hwdata[3:0] == MODE_PWM1))
    begin
      // Positive phases low, negative phases high.
      level_d = {PH_ALL, ~PH_ALL};
    end
    else if (wr_ioctl && (timer_mode_reg_q == MODE_PWM1))
    begin
      // Only the positive phases follow the level set; B side keeps.
      level_d[NPH-1:0] = hwdata[NPH-1:0];
    end
    else if (wr_ioctl)
    begin
      level_d = hwdata[NPIN-1:0];
    end
    else if (crest || trough)
    begin
      level_d = {~pins_q.level[NPIN-1:NPH], ~pins_q.level[NPH-1:0]};
    end
  end

  // ---------------------------------------------------------------
  // Bus slave registers.
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      aph_q <= '0;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      aph_q.addr <= a_now;
      aph_q.wr <= take && hwrite;
      aph_q.rd <= take && !hwrite;
      hrdata_q <= take && !hwrite ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Control registers; standby initialises like power-on reset.
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      timer_mode_reg_q <= MODE_NORMAL;
      count_start_q <= 1'b0;
      output_master_enable_q <= PIN_RST;
      io_control_q <= PIN_RST;
      dead_time_data_q <= TIMER_RST;
    end
    else if (standby)
    begin
      timer_mode_reg_q <= MODE_NORMAL;
      count_start_q <= 1'b0;
      output_master_enable_q <= PIN_RST;
      io_control_q <= PIN_RST;
      dead_time_data_q <= TIMER_RST;
    end
    else
    begin
      if (wr_mode)
        timer_mode_reg_q <= hwdata[3:0];
      if (wr_start)
        count_start_q <= hwdata[0];
      if (wr_outen)
        output_master_enable_q <= hwdata[NPIN-1:0];
      if (wr_ioctl)
        io_control_q <= hwdata[NPIN-1:0];
      if (wr_dead)
        dead_time_data_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      counter_clear_on_match_enable_q <= 1'b0;
      trough_write_enable_q <= 1'b0;
      cce_read_zero_q <= 1'b0;
    end
    else if (standby)
    begin
      counter_clear_on_match_enable_q <= 1'b0;
      trough_write_enable_q <= 1'b0;
      cce_read_zero_q <= 1'b0;
    end
    else
    begin
      if (wr_wave)
      begin
        counter_clear_on_match_enable_q <= cce_set ? 1'b1 : hwdata[WAVE_CCE_BIT] && counter_clear_on_match_enable_q;
        trough_write_enable_q <= hwdata[WAVE_WRE_BIT];
      end
      if (rd_wave_now)
        cce_read_zero_q <= !counter_clear_on_match_enable_q;
      else if (wr_wave)
        cce_read_zero_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Cycle buffers and their transfer.
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cycle_buffer_q <= TIMER_RST;
      ch3_upper_limit_buffer_q <= TIMER_RST;
      cycle_data_q <= TIMER_RST;
      ch3_upper_limit_q <= TIMER_RST;
    end
    else if (standby)
    begin
      cycle_buffer_q <= TIMER_RST;
      ch3_upper_limit_buffer_q <= TIMER_RST;
      cycle_data_q <= TIMER_RST;
      ch3_upper_limit_q <= TIMER_RST;
    end
    else
    begin
      if (wr_cycbuf)
        cycle_buffer_q <= hwdata[15:0];
      if (wr_upbuf)
        ch3_upper_limit_buffer_q <= hwdata[15:0];
      // Both limits load on the same edge; a crest load is first compared
      // at the next crest, a trough load already at this cycle's crest.
      if (xfer)
      begin
        cycle_data_q <= cycle_buffer_q;
        ch3_upper_limit_q <= ch3_upper_limit_buffer_q;
      end
      else if (!running)
      begin
        if (wr_cycbuf)
          cycle_data_q <= hwdata[15:0];
        if (wr_upbuf)
          ch3_upper_limit_q <= hwdata[15:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Counters.
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ch3_counter_q <= CNT_RST;
      ch4_counter_q <= CNT_RST;
      count_up_q <= 1'b1;
    end
    else if (standby || match_clear)
    begin
      ch3_counter_q <= CNT_RST;
      ch4_counter_q <= CNT_RST;
      count_up_q <= 1'b1;
    end
    else if (running && cmp_mode)
    begin
      if (crest)
        count_up_q <= 1'b0;
      else if (trough)
        count_up_q <= 1'b1;
      if (count_up_q && !crest)
      begin
        ch3_counter_q <= ch3_counter_q + CNT_ONE;
        if (ch4_counter_q != cycle_data_q)
          ch4_counter_q <= ch4_counter_q + CNT_ONE;
      end
      else if (!trough)
      begin
        ch3_counter_q <= ch3_counter_q - CNT_ONE;
        if (ch4_counter_q != CNT_RST)
          ch4_counter_q <= ch4_counter_q - CNT_ONE;
      end
      else
      begin
        ch3_counter_q <= ch3_counter_q + CNT_ONE;
        ch4_counter_q <= ch4_counter_q + CNT_ONE;
      end
    end
    else if (running)
    begin
      ch3_counter_q <= ch3_counter_q + CNT_ONE;
      ch4_counter_q <= ch4_counter_q + CNT_ONE;
    end
  end

  // ---------------------------------------------------------------
  // Gate pins: low and released after reset.
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pins_q.level <= PIN_RST;
      pins_q.oe <= PIN_RST;
    end
    else if (standby)
    begin
      pins_q.level <= PIN_RST;
      pins_q.oe <= PIN_RST;
    end
    else
    begin
      pins_q.level <= level_d;
      pins_q.oe <= output_master_enable_q;
    end
  end

  assign hrdata = hrdata_q;
  assign gate_out = pins_q.level;
  assign gate_oe = pins_q.oe;

endmodule
`default_nettype wire

// file: cpwm_gate_drv.sv
`timescale 1ns/1ps
`default_nettype none
module cpwm_gate_drv
  import cpwm_pkg::*;
(
  // Gate pins from the timer.
  input wire logic [cpwm_pkg::NPIN-1:0] gate_out,
  input wire logic [cpwm_pkg::NPIN-1:0] gate_oe,
  // Level seen at the driver inputs.
  output logic [cpwm_pkg::NPIN-1:0] pin_lvl
);
  import cpwm_pkg::*;
  // A released pin falls to the driver's pull-down, which is the inactive level.
  assign pin_lvl = gate_out & gate_oe;
endmodule
`default_nettype wire

// file: cpwm_cycle_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cpwm_cycle_ctrl_chk
  import cpwm_pkg::*;
(
  // Clock, reset and standby.
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic standby,
  // Bus.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Gate pins.
  input wire logic [cpwm_pkg::NPIN-1:0] gate_out,
  input wire logic [cpwm_pkg::NPIN-1:0] gate_oe
);
  import cpwm_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic go = hsel && hready && htrans == HTRANS_NONSEQ;
  wire logic rd_go = go && !hwrite;
  sequence wr_pwm1;
    go && hwrite && haddr[7:0] == ADDR_MODE ##1 hwdata[3:0] == MODE_PWM1;
  endsequence
  sequence wr_outen;
    go && hwrite && haddr[7:0] == ADDR_OUTEN ##1 1'b1;
  endsequence
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_IDLE_DATA: assert property (!rd_go |=> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  AST_UNMAPPED: assert property (rd_go && haddr[7:0] > ADDR_CNT4 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_WAVE_RSVD: assert property (rd_go && haddr[7:0] == ADDR_WAVE |=> hrdata[31:1] == {24'h0, 7'h0} || hrdata[31:1] == {24'h0, 7'h40})
    else $error("waveform reserved bits not zero");
  AST_RESET_OUT: assert property ($fell(rst) |-> gate_out == 6'h00 && gate_oe == 6'h00)
    else $error("gate pins active after reset");
  AST_STANDBY_INIT: assert property (standby |-> ##[1:2] (gate_out == 6'h00 && gate_oe == 6'h00))
    else $error("gate pins not initialised by standby");
  AST_PWM1_LEVELS: assert property (wr_pwm1 |-> ##[1:2] gate_out == 6'h38)
    else $error("mode one levels wrong");
  AST_OE_FOLLOWS: assert property (disable iff (rst || standby) wr_outen |-> ##2 gate_oe == $past(hwdata[5:0], 2))
    else $error("output enable not reflected on pins");
endmodule
bind cpwm_cycle_ctrl cpwm_cycle_ctrl_chk chk_i (.clk_sys(clk_sys), .rst(rst), .standby(standby), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .gate_out(gate_out), .gate_oe(gate_oe));
`default_nettype wire

// file: tb_complementary_pwm_cycle_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_complementary_pwm_cycle_ctrl;
  import cpwm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic standby = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rd_s;
  logic [NPIN-1:0] gate_out;
  logic [NPIN-1:0] gate_oe;
  logic [NPIN-1:0] pin_lvl;
  logic [31:0] v;
  logic [31:0] prev;
  logic [31:0] prev2;
  logic [3:0] modes [3] = '{MODE_CMP_CREST, MODE_CMP_TROUGH, MODE_CMP_BOTH};
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  bit down;

  cpwm_cycle_ctrl dut (.clk_sys(clk_sys), .rst(rst), .standby(standby), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .gate_out(gate_out), .gate_oe(gate_oe));
  cpwm_gate_drv drv (.gate_out(gate_out), .gate_oe(gate_oe), .pin_lvl(pin_lvl));

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) rd_s <= hrdata;
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Bus tasks.
  // ---------------------------------------------------------------
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    hsel <= 1'b1;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    #1;
    v = rd_s;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic meas(input bit exp_down);
    wr(ADDR_START, 32'h1);
    prev = 32'h0;
    prev2 = 32'h0;
    down = 1'b0;
    // The first reads may still show a down run left from the previous run.
    for (int i = 0; i < 30; i++)
    begin
      rd(ADDR_CNT3);
      chk("cnt3_limit", 32'h1, {31'h0, v <= 32'h8});
      if (i >= 10 && v < prev && prev < prev2)
        down = 1'b1;
      prev2 = prev;
      prev = v;
    end
    repeat (10)
    begin
      rd(ADDR_CNT4);
      chk("cnt4_limit", 32'h1, {31'h0, v <= 32'h6});
    end
    wr(ADDR_START, 32'h0);
    chk("count_down", {31'h0, exp_down}, {31'h0, down});
  endtask

  // ---------------------------------------------------------------
  // Tests.
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("gate_out", 32'h0, {26'h0, gate_out});
    chk("gate_oe", 32'h0, {26'h0, gate_oe});
    chk("pins", 32'h0, {26'h0, pin_lvl});
    rd(ADDR_MODE);
    chk("mode", {28'h0, MODE_NORMAL}, v);
    rd(ADDR_UPPER);
    chk("upper", {16'h0, TIMER_RST}, v);
    rd(8'h30);
    chk("unmapped", 32'h0, v);
    $display("Test reset done");
    wr(ADDR_WAVE, 32'h1);
    rd(ADDR_WAVE);
    chk("wave_wre", 32'h1, v);
    wr(ADDR_WAVE, 32'h1);
    wr(ADDR_MODE, {28'h0, MODE_CMP_CREST});
    wr(ADDR_WAVE, 32'h81);
    rd(ADDR_WAVE);
    chk("wave_no_read", 32'h1, v);
    wr(ADDR_WAVE, 32'h81);
    rd(ADDR_WAVE);
    chk("wave_set", 32'h81, v);
    wr(ADDR_WAVE, 32'h0);
    $display("Test clear enable done");
    wr(ADDR_DEAD, 32'h2);
    wr(ADDR_CYCBUF, 32'h6);
    wr(ADDR_UPBUF, 32'h8);
    rd(ADDR_CYCLE);
    chk("cycle", 32'h6, v);
    rd(ADDR_UPPER);
    chk("upper", 32'h8, v);
    meas(1'b1);
    rd(ADDR_WAVE);
    wr(ADDR_WAVE, 32'h80);
    meas(1'b0);
    wr(ADDR_WAVE, 32'h0);
    $display("Test counting done");
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_MODE, {28'h0, modes[i]});
      wr(ADDR_START, 32'h1);
      wr(ADDR_CYCBUF, 32'h8 + i);
      wr(ADDR_UPBUF, 32'hA + i);
      n = 0;
      rd(ADDR_UPPER);
      while (v !== 32'hA + i && n < 40)
      begin
        n++;
        rd(ADDR_UPPER);
      end
      chk("upper_xfer", 32'hA + i, v);
      rd(ADDR_CYCLE);
      chk("cycle_xfer", 32'h8 + i, v);
      wr(ADDR_START, 32'h0);
    end
    $display("Test transfer done");
    wr(ADDR_OUTEN, 32'h3F);
    wr(ADDR_MODE, {28'h0, MODE_PWM1});
    repeat (2) @(posedge clk_sys);
    chk("gate_oe", 32'h3F, {26'h0, gate_oe});
    chk("gate_pwm1", 32'h38, {26'h0, gate_out});
    chk("pins_pwm1", 32'h38, {26'h0, pin_lvl});
    wr(ADDR_IOCTL, 32'h7);
    repeat (2) @(posedge clk_sys);
    chk("b_side", 32'h7, {29'h0, gate_out[5:3]});
    chk("a_side", 32'h7, {29'h0, gate_out[2:0]});
    $display("Test mode one done");
    wr(ADDR_OUTEN, 32'h0);
    wr(ADDR_START, 32'h0);
    wr(ADDR_IOCTL, 32'h0);
    wr(ADDR_MODE, {28'h0, MODE_NORMAL});
    wr(ADDR_OUTEN, 32'h3F);
    wr(ADDR_START, 32'h1);
    standby <= 1'b1;
    @(posedge clk_sys);
    standby <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("oe_standby", 32'h0, {26'h0, gate_oe});
    rd(ADDR_CYCLE);
    chk("cycle_standby", {16'h0, TIMER_RST}, v);
    rd(ADDR_DEAD);
    chk("dead_standby", {16'h0, TIMER_RST}, v);
    $display("Test recovery done");
    print_verdict();
  end
endmodule
`default_nettype wire
